// >>> design/hub_cfg_pkg.sv
// Shared constants for the hub configuration register bank
package hub_cfg_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets on the byte-wide register port
	localparam logic [7:0] ADDR_STATUS_CMD   = 8'h00;
	localparam logic [7:0] ADDR_PROT_LO      = 8'h01;
	localparam logic [7:0] ADDR_CFG_ONE      = 8'h07;
	localparam logic [7:0] ADDR_CFG_TWO      = 8'h08;
	localparam logic [7:0] ADDR_FIXED_MASK   = 8'h09;
	localparam logic [7:0] ADDR_SP_OFF_MASK  = 8'h0A;
	localparam logic [7:0] ADDR_PROT_HI      = 8'h10;

	// Reset values
	localparam logic [7:0] CFG_RESET_VAL     = 8'h00;

	// Byte one fields
	localparam int CFG1_POWER_MODE    = 7;
	localparam int CFG1_LED_SUPPORT   = 6;
	localparam int CFG1_FS_ONLY       = 5;
	localparam int CFG1_PER_PORT_TT   = 4;
	localparam int CFG1_EOP_SUPPRESS  = 3;
	localparam int CFG1_OC_SENSE_HI   = 2;
	localparam int CFG1_OC_SENSE_LO   = 1;
	localparam int CFG1_PWR_SWITCH    = 0;

	// Byte two fields
	localparam int HUB_CONFIG_BYTE_TWO_DYNAMIC       = 7;
	localparam int HUB_CONFIG_BYTE_TWO_OC_DELAY_HI   = 5;
	localparam int HUB_CONFIG_BYTE_TWO_OC_DELAY_LO   = 4;
	localparam int HUB_CONFIG_BYTE_TWO_COMPOUND      = 3;
	localparam logic [7:0] HUB_CONFIG_BYTE_TWO_WRITABLE = 8'hB8;

	// Port masks: bit 0 reserved, reads zero
	localparam logic [7:0] PORT_MASK_WRITABLE = 8'hFE;

	// Status/command bits
	localparam int STCMD_SOFT_RESET = 2;
	localparam int STCMD_LOCK       = 1;

	// Over-current sensing codes
	typedef enum logic [1:0] {
		OC_GANGED   = 2'h0,
		OC_PER_PORT = 2'h1
	} oc_sense_type;

	// Over-current delay figures in microseconds
	localparam int OC_DELAY0_US = 100;
	localparam int OC_DELAY1_US = 2000;
	localparam int OC_DELAY2_US = 4000;
	localparam int OC_DELAY3_US = 6000;
	localparam int CLK_MHZ      = 100;

endpackage : hub_cfg_pkg

// >>> design/cfg_byte_if.sv
// Carrier between the register bank and its field decoder
`timescale 1ns/1ns
interface cfg_byte_if;
	logic [7:0] cfgOne;
	logic [7:0] cfgTwo;
	logic [7:0] offMask;
	logic       supplySense;

	modport bank
	(
		output cfgOne,
		output cfgTwo,
		output offMask,
		output supplySense
	);
	modport decode
	(
		input  cfgOne,
		input  cfgTwo,
		input  offMask,
		input  supplySense
	);
endinterface : cfg_byte_if

// >>> design/pin_sync.sv
// Three-stage synchroniser with agreement filter for a pin level
`timescale 1ns/1ns
module pin_sync
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic pinIn,
	output logic      level
);
	logic stage1;
	logic stage2;
	logic stage3;

	// First stage feeds only the second
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end
		else
		begin
			stage1 <= pinIn;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Change counts only once the last two stages agree
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			level <= 1'b0;
		else if (stage2 == stage3)
			level <= stage3;
	end
endmodule : pin_sync

// >>> design/hub_cfg_decode.sv
// Decodes configuration bytes into hub control levels
`timescale 1ns/1ns
module hub_cfg_decode
(
	input  wire logic         mclk,
	input  wire logic         rst,
	cfg_byte_if.decode        cfg,
	output logic              selfPowered,
	output logic              perPortOcSense,
	output logic [19:0]       ocDelayCycles,
	output logic [7:0]        portDisable
);
	logic modeNext;
	logic [19:0] delayNext;

	// Power mode: dynamic switching follows the supply pin
	always_comb
	begin
		if (cfg.cfgTwo[hub_cfg_pkg::HUB_CONFIG_BYTE_TWO_DYNAMIC])
			modeNext = cfg.supplySense;
		else
			modeNext = cfg.cfgOne[hub_cfg_pkg::CFG1_POWER_MODE];
	end

	// Over-current delay in clock cycles; 20 bits so the 6 ms count is not cut
	always_comb
	begin
		unique case (cfg.cfgTwo[hub_cfg_pkg::HUB_CONFIG_BYTE_TWO_OC_DELAY_HI:hub_cfg_pkg::HUB_CONFIG_BYTE_TWO_OC_DELAY_LO])
			2'h0: delayNext = 20'(hub_cfg_pkg::OC_DELAY0_US * hub_cfg_pkg::CLK_MHZ);
			2'h1: delayNext = 20'(hub_cfg_pkg::OC_DELAY1_US * hub_cfg_pkg::CLK_MHZ);
			2'h2: delayNext = 20'(hub_cfg_pkg::OC_DELAY2_US * hub_cfg_pkg::CLK_MHZ);
			2'h3: delayNext = 20'(hub_cfg_pkg::OC_DELAY3_US * hub_cfg_pkg::CLK_MHZ);
		endcase
	end

	// Registered outputs; unused sense codes fall back to ganged
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			selfPowered    <= 1'b0;
			perPortOcSense <= 1'b0;
			ocDelayCycles  <= 20'h00000;
			portDisable    <= 8'h00;
		end
		else
		begin
			selfPowered    <= modeNext;
			perPortOcSense <= (cfg.cfgOne[hub_cfg_pkg::CFG1_OC_SENSE_HI:hub_cfg_pkg::CFG1_OC_SENSE_LO]
				== hub_cfg_pkg::OC_PER_PORT);
			ocDelayCycles  <= delayNext;
			portDisable    <= modeNext ? cfg.offMask : 8'h00;
		end
	end
endmodule : hub_cfg_decode

// >>> design/hub_config_register_bank.sv
// Hub configuration register bank behind the byte-wide register port
`timescale 1ns/1ns
module hub_config_register_bank
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regWdata,
	output logic [7:0]       regRdata,
	input  wire logic        local_supply_sense_pin,
	output logic             power_mode_select,
	output logic             led_indicator_support,
	output logic             full_speed_only,
	output logic             per_port_translator_en,
	output logic             frame_end_eop_suppress,
	output logic [1:0]       overcurrent_sense_mode,
	output logic             port_power_switch_mode,
	output logic [1:0]       overcurrent_delay_sel,
	output logic             compoundDevice,
	output logic [7:0]       fixed_port_mask,
	output logic [7:0]       self_power_port_off_mask,
	output logic             config_lock,
	output logic             selfPowered,
	output logic             perPortOcSense,
	output logic [19:0]      ocDelayCycles,
	output logic [7:0]       portDisable
);
	logic [7:0] cfgOne_reg;
	logic [7:0] cfgTwo_reg;
	logic [7:0] fixedMask_reg;
	logic [7:0] offMask_reg;
	logic       lock_reg;
	logic       softReset_reg;
	logic       supplyLevel;
	logic       inProtRange;
	logic       wrEnable;
	logic [7:0] readNext;

	cfg_byte_if cfgBus ();

	pin_sync supplySync
	(
		.mclk   (mclk),
		.rst    (rst),
		.pinIn  (local_supply_sense_pin),
		.level  (supplyLevel)
	);

	// Configuration memory writes, gated by the lock
	assign inProtRange = (regAddr >= hub_cfg_pkg::ADDR_PROT_LO) && (regAddr <= hub_cfg_pkg::ADDR_PROT_HI);
	assign wrEnable    = regWrite && !(lock_reg && inProtRange);

	// Soft reset pulse: one cycle, then self-clears
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			softReset_reg <= 1'b0;
		else
			softReset_reg <= regWrite && (regAddr == hub_cfg_pkg::ADDR_STATUS_CMD)
				&& regWdata[hub_cfg_pkg::STCMD_SOFT_RESET] && !softReset_reg;
	end

	// Lock is write-once; only the hard reset clears it
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			lock_reg <= 1'b0;
		else if (regWrite && (regAddr == hub_cfg_pkg::ADDR_STATUS_CMD) && regWdata[hub_cfg_pkg::STCMD_LOCK])
			lock_reg <= 1'b1;
	end

	// Byte one
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cfgOne_reg <= hub_cfg_pkg::CFG_RESET_VAL;
		else if (softReset_reg)
			cfgOne_reg <= hub_cfg_pkg::CFG_RESET_VAL;
		else if (wrEnable && regAddr == hub_cfg_pkg::ADDR_CFG_ONE)
			cfgOne_reg <= regWdata;
	end

	// Byte two; reserved bits never stored
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			cfgTwo_reg <= hub_cfg_pkg::CFG_RESET_VAL;
		else if (softReset_reg)
			cfgTwo_reg <= hub_cfg_pkg::CFG_RESET_VAL;
		else if (wrEnable && regAddr == hub_cfg_pkg::ADDR_CFG_TWO)
			cfgTwo_reg <= regWdata & hub_cfg_pkg::HUB_CONFIG_BYTE_TWO_WRITABLE;
	end

	// Port masks; bit 0 is held at zero
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			fixedMask_reg <= hub_cfg_pkg::CFG_RESET_VAL;
			offMask_reg   <= hub_cfg_pkg::CFG_RESET_VAL;
		end
		else if (softReset_reg)
		begin
			fixedMask_reg <= hub_cfg_pkg::CFG_RESET_VAL;
			offMask_reg   <= hub_cfg_pkg::CFG_RESET_VAL;
		end
		else if (wrEnable)
		begin
			if (regAddr == hub_cfg_pkg::ADDR_FIXED_MASK)
				fixedMask_reg <= regWdata & hub_cfg_pkg::PORT_MASK_WRITABLE;
			if (regAddr == hub_cfg_pkg::ADDR_SP_OFF_MASK)
				offMask_reg <= regWdata & hub_cfg_pkg::PORT_MASK_WRITABLE;
		end
	end

	// Read mux; unmapped offsets read zero
	always_comb
	begin
		unique case (regAddr)
			hub_cfg_pkg::ADDR_STATUS_CMD:  readNext = {6'h00, lock_reg, 1'b0};
			hub_cfg_pkg::ADDR_CFG_ONE:     readNext = cfgOne_reg;
			hub_cfg_pkg::ADDR_CFG_TWO:     readNext = cfgTwo_reg;
			hub_cfg_pkg::ADDR_FIXED_MASK:  readNext = fixedMask_reg;
			hub_cfg_pkg::ADDR_SP_OFF_MASK: readNext = offMask_reg;
			default:                       readNext = 8'h00;
		endcase
	end

	// Read data registered, updated on a read strobe
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
			regRdata <= 8'h00;
		else if (regRead)
			regRdata <= readNext;
	end

	// Field outputs straight from the stored bytes
	assign power_mode_select      = cfgOne_reg[hub_cfg_pkg::CFG1_POWER_MODE];
	assign led_indicator_support  = cfgOne_reg[hub_cfg_pkg::CFG1_LED_SUPPORT];
	assign full_speed_only        = cfgOne_reg[hub_cfg_pkg::CFG1_FS_ONLY];
	assign per_port_translator_en = cfgOne_reg[hub_cfg_pkg::CFG1_PER_PORT_TT];
	assign frame_end_eop_suppress = cfgOne_reg[hub_cfg_pkg::CFG1_EOP_SUPPRESS];
	assign overcurrent_sense_mode = cfgOne_reg[hub_cfg_pkg::CFG1_OC_SENSE_HI:hub_cfg_pkg::CFG1_OC_SENSE_LO];
	assign port_power_switch_mode = cfgOne_reg[hub_cfg_pkg::CFG1_PWR_SWITCH];
	assign overcurrent_delay_sel  = cfgTwo_reg[hub_cfg_pkg::HUB_CONFIG_BYTE_TWO_OC_DELAY_HI:hub_cfg_pkg::HUB_CONFIG_BYTE_TWO_OC_DELAY_LO];
	assign compoundDevice         = cfgTwo_reg[hub_cfg_pkg::HUB_CONFIG_BYTE_TWO_COMPOUND];
	assign fixed_port_mask        = fixedMask_reg;
	assign self_power_port_off_mask = offMask_reg;
	assign config_lock            = lock_reg;

	assign cfgBus.cfgOne      = cfgOne_reg;
	assign cfgBus.cfgTwo      = cfgTwo_reg;
	assign cfgBus.offMask     = offMask_reg;
	assign cfgBus.supplySense = supplyLevel;

	// Derived power and over-current controls
	hub_cfg_decode decoder
	(
		.mclk           (mclk),
		.rst            (rst),
		.cfg            (cfgBus.decode),
		.selfPowered    (selfPowered),
		.perPortOcSense (perPortOcSense),
		.ocDelayCycles  (ocDelayCycles),
		.portDisable    (portDisable)
	);
endmodule : hub_config_register_bank

// >>> test/cfg_host.sv
// Register-port host that loads the hub configuration
`timescale 1ns/1ns
module cfg_host
(
	input  wire logic       mclk,
	input  wire logic [7:0] regRdata,
	output logic [7:0]      regAddr,
	output logic            regWrite,
	output logic            regRead,
	output logic [7:0]      regWdata
);
	// Idle bus at time zero
	initial
	begin
		regAddr = 8'h00;
		regWrite = 1'b0;
		regRead = 1'b0;
		regWdata = 8'h00;
	end

	// One-cycle write; released data flips so stale values never look valid
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		regAddr = a;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge mclk);
		regWrite = 1'b0;
		regWdata = ~d;
	endtask : wr

	// Read data is taken once the sampling edge has passed
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge mclk);
		regAddr = a;
		regRead = 1'b1;
		@(negedge mclk);
		regRead = 1'b0;
		d = regRdata;
	endtask : rd
endmodule : cfg_host

// >>> test/hub_cfg_asserts.sv
// Port-level assertions for the hub configuration register bank
`timescale 1ns/1ns
module hub_cfg_asserts
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  regAddr,
	input  wire logic        regWrite,
	input  wire logic        regRead,
	input  wire logic [7:0]  regWdata,
	input  wire logic [7:0]  regRdata,
	input  wire logic        power_mode_select,
	input  wire logic [1:0]  overcurrent_delay_sel,
	input  wire logic [7:0]  fixed_port_mask,
	input  wire logic [7:0]  self_power_port_off_mask,
	input  wire logic        config_lock,
	input  wire logic        selfPowered,
	input  wire logic        perPortOcSense,
	input  wire logic [19:0] ocDelayCycles,
	input  wire logic [7:0]  portDisable
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);

	// Accepted writes, a quiet cycle after, and the soft reset command
	sequence s_wr(a); regWrite && regAddr == a && !config_lock; endsequence
	sequence s_wrQuiet(a); s_wr(a) ##1 !regWrite; endsequence
	sequence s_soft; regWrite && regAddr == 8'h00 && regWdata[2] ##1 !regWrite [*2]; endsequence

	property p_powerBit; s_wr(8'h07) |=> power_mode_select == $past(regWdata[7]); endproperty
	a_powerBit: assert property (p_powerBit) else $error("power mode bit wrong");
	property p_senseDecode; s_wrQuiet(8'h07) |=> perPortOcSense == ($past(regWdata[2:1], 2) == 2'b01); endproperty
	a_senseDecode: assert property (p_senseDecode) else $error("sense decode wrong");
	property p_delaySel; s_wr(8'h08) |=> overcurrent_delay_sel == $past(regWdata[5:4]); endproperty
	a_delaySel: assert property (p_delaySel) else $error("delay select wrong");
	property p_delayShort; overcurrent_delay_sel == 2'b00 [*3] |-> ocDelayCycles == 20'h02710; endproperty
	a_delayShort: assert property (p_delayShort) else $error("short delay count wrong");
	property p_delayLong; overcurrent_delay_sel == 2'b11 [*3] |-> ocDelayCycles == 20'h927C0; endproperty
	a_delayLong: assert property (p_delayLong) else $error("long delay count wrong");
	property p_maskBit0; fixed_port_mask[0] == 1'b0 && self_power_port_off_mask[0] == 1'b0; endproperty
	a_maskBit0: assert property (p_maskBit0) else $error("mask bit 0 set");
	property p_busDisable; !selfPowered [*3] |-> portDisable == 8'h00; endproperty
	a_busDisable: assert property (p_busDisable) else $error("port off while bus powered");
	property p_lockHold; config_lock && regWrite && regAddr inside {[8'h01:8'h10]}
		|=> $stable(fixed_port_mask) && $stable(power_mode_select); endproperty
	a_lockHold: assert property (p_lockHold) else $error("locked write took effect");
	property p_lockSticky; config_lock |=> config_lock; endproperty
	a_lockSticky: assert property (p_lockSticky) else $error("lock dropped");
	property p_softClear; s_soft |=> fixed_port_mask == 8'h00 && power_mode_select == 1'b0
		&& overcurrent_delay_sel == 2'b00; endproperty
	a_softClear: assert property (p_softClear) else $error("soft reset left state");
	property p_reservedRead; regRead && regAddr == 8'h08 |=> (regRdata & 8'h47) == 8'h00; endproperty
	a_reservedRead: assert property (p_reservedRead) else $error("reserved bits read set");
endmodule : hub_cfg_asserts

bind hub_config_register_bank hub_cfg_asserts i_hub_cfg_asserts (.*);

// >>> test/testbench.sv
// Self-checking bench for the hub configuration register bank
`timescale 1ns/1ns
module testbench;
	logic        mclk, rst, local_supply_sense_pin, regWrite, regRead;
	logic [7:0]  regAddr, regWdata, regRdata, fixed_port_mask, self_power_port_off_mask, portDisable, rv;
	logic        power_mode_select, led_indicator_support, full_speed_only, per_port_translator_en;
	logic        frame_end_eop_suppress, port_power_switch_mode, compoundDevice, config_lock;
	logic        selfPowered, perPortOcSense;
	logic [1:0]  overcurrent_sense_mode, overcurrent_delay_sel;
	logic [19:0] ocDelayCycles;
	int          bad_count = 0;
	int          comparisons = 0;

	hub_config_register_bank i_hub_config_register_bank (.*);
	cfg_host i_cfg_host (.*);

	// Free-running 100 MHz clock
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task chk_count(input string what, input logic [19:0] exp, input logic [19:0] got);
		comparisons++;
		if (got !== exp)
		begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_count

	task wrap_up;
		$display("comparisons %0d mismatches %0d", comparisons, bad_count);
		if (bad_count == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	// Pin path is filtered, so allow a bounded settle time
	task wait_sp(input logic e);
		int n;
		n = 0;
		while (selfPowered !== e && n < 20)
		begin
			@(negedge mclk);
			n++;
		end
		chk("selfPowered", {15'h0, e}, {15'h0, selfPowered});
		if (selfPowered !== e)
			wrap_up;
	endtask : wait_sp

	task t_reset;
		for (int a = 7; a <= 10; a++)
		begin
			i_cfg_host.rd(a[7:0], rv);
			chk("reset value", 16'h0000, {8'h00, rv});
		end
		$display("reset test done");
	endtask : t_reset

	task t_byteOne;
		logic [7:0] v[8];
		v = '{8'h80, 8'h40, 8'h20, 8'h10, 8'h08, 8'h02, 8'h01, 8'h06};
		foreach (v[i])
		begin
			i_cfg_host.wr(8'h07, v[i]);
			chk("byte one fields", {8'h00, v[i]}, {8'h00, power_mode_select, led_indicator_support, full_speed_only,
				per_port_translator_en, frame_end_eop_suppress, overcurrent_sense_mode, port_power_switch_mode});
			@(negedge mclk);
			chk("perPortOcSense", {15'h0, v[i] == 8'h02}, {15'h0, perPortOcSense});
			i_cfg_host.rd(8'h07, rv);
			chk("byte one read", {8'h00, v[i]}, {8'h00, rv});
		end
		$display("byte one test done");
	endtask : t_byteOne

	task t_byteTwo;
		logic [19:0] dly[4];
		// 0.1, 2, 4 and 6 ms at 100 MHz
		dly = '{20'h02710, 20'h30D40, 20'h61A80, 20'h927C0};
		for (int c = 3; c >= 0; c--)
		begin
			i_cfg_host.wr(8'h08, {2'b00, c[1:0], 4'h8});
			chk("delay and compound", {13'h0, c[1:0], 1'b1}, {13'h0, overcurrent_delay_sel, compoundDevice});
			repeat (2) @(negedge mclk);
			chk_count("ocDelayCycles", dly[c], ocDelayCycles);
		end
		repeat (2) @(negedge mclk);
		chk_count("ocDelayCycles", 20'h02710, ocDelayCycles);
		i_cfg_host.wr(8'h08, 8'hFF);
		i_cfg_host.rd(8'h08, rv);
		chk("byte two read", 16'h00B8, {8'h00, rv});
		$display("byte two test done");
	endtask : t_byteTwo

	task t_power;
		i_cfg_host.wr(8'h09, 8'hFF);
		i_cfg_host.rd(8'h09, rv);
		chk("fixed mask read", 16'h00FE, {8'h00, rv});
		chk("fixed_port_mask", 16'h00FE, {8'h00, fixed_port_mask});
		i_cfg_host.wr(8'h0A, 8'h0F);
		i_cfg_host.rd(8'h0A, rv);
		chk("off mask read", 16'h000E, {8'h00, rv});
		chk("self_power_port_off_mask", 16'h000E, {8'h00, self_power_port_off_mask});
		i_cfg_host.wr(8'h08, 8'h00);
		i_cfg_host.wr(8'h07, 8'h80);
		wait_sp(1'b1);
		@(negedge mclk);
		chk("portDisable", 16'h000E, {8'h00, portDisable});
		i_cfg_host.wr(8'h08, 8'h80);
		wait_sp(1'b0);
		local_supply_sense_pin = 1'b1;
		wait_sp(1'b1);
		local_supply_sense_pin = 1'b0;
		wait_sp(1'b0);
		$display("power test done");
	endtask : t_power

	task t_lock;
		i_cfg_host.wr(8'h00, 8'h04);
		repeat (2) @(negedge mclk);
		i_cfg_host.rd(8'h0A, rv);
		chk("off mask after soft reset", 16'h0000, {8'h00, rv});
		i_cfg_host.rd(8'h00, rv);
		chk("command bit", 16'h0000, {8'h00, rv});
		i_cfg_host.wr(8'h09, 8'h06);
		i_cfg_host.wr(8'h00, 8'h02);
		chk("config_lock", 16'h0001, {15'h0, config_lock});
		i_cfg_host.wr(8'h09, 8'h00);
		i_cfg_host.rd(8'h09, rv);
		chk("locked mask", 16'h0006, {8'h00, rv});
		i_cfg_host.rd(8'h20, rv);
		chk("unmapped read", 16'h0000, {8'h00, rv});
		// Soft reset keeps the lock; only the hard reset drops it
		i_cfg_host.wr(8'h00, 8'h04);
		repeat (2) @(negedge mclk);
		chk("config_lock", 16'h0001, {15'h0, config_lock});
		i_cfg_host.rd(8'h00, rv);
		chk("status after lock", 16'h0002, {8'h00, rv});
		rst = 1'b1;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		chk("config_lock", 16'h0000, {15'h0, config_lock});
		i_cfg_host.wr(8'h09, 8'h0C);
		i_cfg_host.rd(8'h09, rv);
		chk("mask after hard reset", 16'h000C, {8'h00, rv});
		$display("lock test done");
	endtask : t_lock

	// Reset held five cycles, then the scenarios in turn
	initial
	begin
		rst = 1'b1;
		local_supply_sense_pin = 1'b0;
		repeat (5) @(negedge mclk);
		rst = 1'b0;
		t_reset;
		t_byteOne;
		t_byteTwo;
		t_power;
		t_lock;
		wrap_up;
	end
endmodule : testbench
